// [aes_top.sv]
// converter event status flags, interrupt enable register and interrupt output
`timescale 1ns/1ps

module aes_top (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire aes_pkg::aes_cfg_t cfg,
    input  wire aes_pkg::aes_evt_t evt,
    input  wire logic [31:0]       mmr_addr,
    input  wire logic              mmr_rd,
    input  wire logic              mmr_wr,
    input  wire logic [31:0]       mmr_wdata,
    output logic [31:0]            mmr_rdata_r,
    output logic [15:0]            converter_event_status_r,
    output logic                   converter_irq_r
);
    logic [7:0]                converter_irq_enable_r;
    logic [aes_pkg::RES_W-1:0] primary_result_data_r;
    logic [aes_pkg::RES_W-1:0] aux_result_data_r;
    logic                      primary_result_ready_r;
    logic                      aux_result_ready_r;
    logic                      aux_read_seen_r;
    logic                      accum_threshold_exceeded_r;
    logic                      primary_gross_overrange;
    logic                      primary_threshold_exceeded;
    logic                      ovr_tick;
    logic [aes_pkg::CNT_W-1:0] threshold_count_value;
    logic                      prim_rd;
    logic                      aux_rd;
    logic                      en_wr;
    logic                      prim_store;
    logic                      aux_store;
    logic [15:0]               status_nxt;
    logic [31:0]               rdata_nxt;

    // register access decode
    assign prim_rd = mmr_rd && (mmr_addr == aes_pkg::PRIM_DATA_ADDR);
    assign aux_rd  = mmr_rd && (mmr_addr == aes_pkg::AUX_DATA_ADDR);
    assign en_wr   = mmr_wr && (mmr_addr == aes_pkg::IRQ_EN_ADDR);

    // a result is stored only when its ready flag is clear, or the core sleeps
    assign prim_store = evt.prim_valid && cfg.prim_en
                        && (!primary_result_ready_r || evt.core_powered_down);
    assign aux_store  = evt.aux_valid && cfg.aux_en
                        && (!aux_result_ready_r || evt.core_powered_down);

    aes_overrange u_ovr (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .overrange_en (cfg.overrange_en),
        .gross_over   (evt.gross_over),
        .gain_change  (evt.gain_change),
        .tick_r       (ovr_tick),
        .flag_r       (primary_gross_overrange)
    );

    aes_thresh u_thr (
        .core_clk      (core_clk),
        .rst_b         (rst_b),
        .comparator_en (cfg.comparator_en),
        .counter_en    (cfg.counter_en),
        .result_valid  (evt.prim_valid && cfg.prim_en),
        .result        (evt.prim_result),
        .level         (cfg.primary_threshold_level),
        .count_limit   (cfg.threshold_count_limit),
        .count_value_r (threshold_count_value),
        .flag_r        (primary_threshold_exceeded)
    );

    // result data registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            primary_result_data_r <= aes_pkg::DATA_RESET;
            aux_result_data_r     <= aes_pkg::DATA_RESET;
        end else begin
            if (prim_store) begin
                primary_result_data_r <= evt.prim_result;
            end
            if (aux_store) begin
                aux_result_data_r <= evt.aux_result;
            end
        end
    end

    // primary ready: set wins over the read that clears it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            primary_result_ready_r <= 1'b0;
        end else if (prim_store || evt.cal_done) begin
            primary_result_ready_r <= 1'b1;
        end else if (prim_rd) begin
            primary_result_ready_r <= 1'b0;
        end
    end

    // aux read is remembered until the following primary read completes the pair
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aux_read_seen_r <= 1'b0;
        end else if (aux_rd) begin
            aux_read_seen_r <= 1'b1;
        end else if (prim_rd) begin
            aux_read_seen_r <= 1'b0;
        end
    end

    // aux ready clears only on primary read after aux read, even if primary is off
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aux_result_ready_r <= 1'b0;
        end else if (aux_store || evt.cal_done) begin
            aux_result_ready_r <= 1'b1;
        end else if (prim_rd && aux_read_seen_r) begin
            aux_result_ready_r <= 1'b0;
        end
    end

    // accumulator compare, unsigned as held by the accumulator
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            accum_threshold_exceeded_r <= 1'b0;
        end else begin
            accum_threshold_exceeded_r <= evt.primary_accumulator
                                          > cfg.accum_threshold_level;
        end
    end

    // interrupt enable register; reserved bits held at zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            converter_irq_enable_r <= aes_pkg::IRQ_EN_RESET;
        end else if (en_wr) begin
            converter_irq_enable_r <= mmr_wdata[7:0] & aes_pkg::IRQ_EN_MASK;
        end
    end

    // status image; positions shared with the enable register
    always_comb begin
        status_nxt                         = aes_pkg::STATUS_RESET;
        status_nxt[aes_pkg::PRIM_RDY_BIT]  = primary_result_ready_r;
        status_nxt[aes_pkg::AUX_RDY_BIT]   = aux_result_ready_r;
        status_nxt[aes_pkg::OVR_BIT]       = primary_gross_overrange;
        status_nxt[aes_pkg::THEX_BIT]      = primary_threshold_exceeded;
        status_nxt[aes_pkg::ATHEX_BIT]     = accum_threshold_exceeded_r;
    end

    // status output register and interrupt; level, held while any enabled flag is up
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            converter_event_status_r <= aes_pkg::STATUS_RESET;
            converter_irq_r          <= 1'b0;
        end else begin
            converter_event_status_r <= status_nxt;
            converter_irq_r          <= |(status_nxt[7:0]
                                          & converter_irq_enable_r);
        end
    end

    // read data mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (mmr_addr)
            aes_pkg::STATUS_ADDR:    rdata_nxt = {16'h0000, status_nxt};
            aes_pkg::IRQ_EN_ADDR:    rdata_nxt = {24'h00_0000, converter_irq_enable_r};
            aes_pkg::PRIM_DATA_ADDR: rdata_nxt = {8'h00, primary_result_data_r};
            aes_pkg::AUX_DATA_ADDR:  rdata_nxt = {8'h00, aux_result_data_r};
            default:                 rdata_nxt = 32'h0000_0000;
        endcase
    end

    // read data registered, valid the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mmr_rdata_r <= 32'h0000_0000;
        end else if (mmr_rd) begin
            mmr_rdata_r <= rdata_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // aux read, a quiet cycle, then primary read with no set landing on the clear
    sequence s_aux_then_prim;
        aux_rd ##1 !prim_rd ##1 (prim_rd && !aux_store && !evt.cal_done);
    endsequence

    property p_aux_pair_clear;
        s_aux_then_prim |=> !aux_result_ready_r;
    endproperty
    a_aux_pair_clear: assert property (p_aux_pair_clear) else $error("aux pair read failed");

    property p_aux_clear;
        (prim_rd && aux_read_seen_r && !aux_store && !evt.cal_done) |=> !aux_result_ready_r;
    endproperty
    a_aux_clear: assert property (p_aux_clear) else $error("aux ready not cleared");

    property p_aux_hold;
        (aux_result_ready_r && !prim_rd) |=> aux_result_ready_r;
    endproperty
    a_aux_hold: assert property (p_aux_hold) else $error("aux ready cleared without read");

    property p_prim_set;
        (evt.prim_valid && cfg.prim_en && !primary_result_ready_r) |=> primary_result_ready_r;
    endproperty
    a_prim_set: assert property (p_prim_set) else $error("primary ready not set");

    property p_prim_clear;
        (prim_rd && !prim_store && !evt.cal_done) |=> !primary_result_ready_r;
    endproperty
    a_prim_clear: assert property (p_prim_clear) else $error("primary ready not cleared");

    property p_cal_sets;
        evt.cal_done |=> (primary_result_ready_r && aux_result_ready_r);
    endproperty
    a_cal_sets: assert property (p_cal_sets) else $error("calibration did not set ready");

    property p_no_overwrite;
        (primary_result_ready_r && !evt.core_powered_down) |=> $stable(primary_result_data_r);
    endproperty
    a_no_overwrite: assert property (p_no_overwrite) else $error("result overwritten");

    property p_irq_gate;
        ((status_nxt[7:0] & converter_irq_enable_r) == 8'h00) |=> !converter_irq_r;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("masked source raised irq");

    property p_irq_level;
        (status_nxt[aes_pkg::OVR_BIT] && converter_irq_enable_r[aes_pkg::OVR_BIT])
            |=> converter_irq_r ##1 (converter_irq_r || !$past(primary_gross_overrange)
                                     || !$past(converter_irq_enable_r[aes_pkg::OVR_BIT]));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not held");

    property p_en_write;
        en_wr |=> (converter_irq_enable_r == ($past(mmr_wdata[7:0]) & aes_pkg::IRQ_EN_MASK));
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write wrong");

    property p_accum;
        (evt.primary_accumulator > cfg.accum_threshold_level) |=> accum_threshold_exceeded_r;
    endproperty
    a_accum: assert property (p_accum) else $error("accumulator flag not set");

    property p_aux_set;
        (evt.aux_valid && cfg.aux_en && !aux_result_ready_r) |=> aux_result_ready_r;
    endproperty
    a_aux_set: assert property (p_aux_set) else $error("aux ready not set");

    property p_aux_data;
        (evt.aux_valid && cfg.aux_en && !aux_result_ready_r)
            |=> (aux_result_data_r == $past(evt.aux_result));
    endproperty
    a_aux_data: assert property (p_aux_data) else $error("aux result not stored");

    property p_prim_data;
        (evt.prim_valid && cfg.prim_en && !primary_result_ready_r)
            |=> (primary_result_data_r == $past(evt.prim_result));
    endproperty
    a_prim_data: assert property (p_prim_data) else $error("primary result not stored");

    property p_aux_keep;
        (aux_result_ready_r && !evt.core_powered_down) |=> $stable(aux_result_data_r);
    endproperty
    a_aux_keep: assert property (p_aux_keep) else $error("aux result overwritten");

    property p_en_hold;
        !en_wr |=> $stable(converter_irq_enable_r);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable changed unwritten");

    property p_irq_raise;
        (|(status_nxt[7:0] & converter_irq_enable_r)) |=> converter_irq_r;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("enabled flag gave no irq");

    property p_ovr_image;
        1'b1 |=> (converter_event_status_r[aes_pkg::OVR_BIT]
                  == $past(primary_gross_overrange));
    endproperty
    a_ovr_image: assert property (p_ovr_image) else $error("overrange status wrong");

    property p_thex_image;
        1'b1 |=> (converter_event_status_r[aes_pkg::THEX_BIT]
                  == $past(primary_threshold_exceeded));
    endproperty
    a_thex_image: assert property (p_thex_image) else $error("comparator status wrong");
endmodule

// [aes_pkg.sv]
// package of constants and carrier types for the converter event status block
package aes_pkg;
    // memory-mapped addresses
    localparam logic [31:0] STATUS_ADDR     = 32'hFFFF_0500;
    localparam logic [31:0] IRQ_EN_ADDR     = 32'hFFFF_0504;
    localparam logic [31:0] PRIM_DATA_ADDR  = 32'hFFFF_0520;
    localparam logic [31:0] AUX_DATA_ADDR   = 32'hFFFF_0524;
    // status and enable bit positions
    localparam int PRIM_RDY_BIT   = 0;
    localparam int AUX_RDY_BIT    = 1;
    localparam int OVR_BIT        = 3;
    localparam int THEX_BIT       = 4;
    localparam int ATHEX_BIT      = 6;
    localparam int OVR_CFG_BIT    = 2;
    // implemented enable bits; reserved 7, 5 and 2 read as zero
    localparam logic [7:0] IRQ_EN_MASK  = 8'h5B;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [23:0] DATA_RESET   = 24'h00_0000;
    // widths
    localparam int RES_W   = 24;
    localparam int ACC_W   = 32;
    localparam int CNT_W   = 8;
    // overrange evaluation period
    localparam int CLK_HZ          = 25_000_000;
    localparam int OVR_PERIOD_US   = 125;
    localparam int OVR_TICK_CYCLES = (CLK_HZ / 1_000_000) * OVR_PERIOD_US;
    localparam int TICK_W          = 12;

    // configuration bits coming from the configuration and control registers
    typedef struct packed {
        logic                comparator_en;
        logic                counter_en;
        logic                overrange_en;
        logic                prim_en;
        logic                aux_en;
        logic [RES_W-1:0]    primary_threshold_level;
        logic [CNT_W-1:0]    threshold_count_limit;
        logic [ACC_W-1:0]    accum_threshold_level;
    } aes_cfg_t;

    // conversion events from the datapath
    typedef struct packed {
        logic                prim_valid;
        logic [RES_W-1:0]    prim_result;
        logic                aux_valid;
        logic [RES_W-1:0]    aux_result;
        logic                cal_done;
        logic                gross_over;
        logic                gain_change;
        logic                core_powered_down;
        logic [ACC_W-1:0]    primary_accumulator;
    } aes_evt_t;
endpackage

// [aes_overrange.sv]
// gross overrange flag, sampled on a fixed period tick
`timescale 1ns/1ps
module aes_overrange (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic overrange_en,
    input  wire logic gross_over,
    input  wire logic gain_change,
    output logic      tick_r,
    output logic      flag_r
);
    localparam logic [11:0] TICK_LAST = 12'(aes_pkg::OVR_TICK_CYCLES - 1);

    logic [11:0] tick_cnt_r;

    // period divider, one-cycle pulse every 125 us
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_r <= 12'h000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= 12'h000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 12'h001;
            tick_r     <= 1'b0;
        end
    end

    // sticky flag; disabling clears, a gain change clears unless a set lands too
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_r <= 1'b0;
        end else if (!overrange_en) begin
            flag_r <= 1'b0;
        end else if (tick_r && gross_over) begin
            flag_r <= 1'b1;
        end else if (gain_change) begin
            flag_r <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_ovr_disable;
        !overrange_en |=> !flag_r;
    endproperty
    a_ovr_disable: assert property (p_ovr_disable) else $error("flag not cleared");

    property p_ovr_only_on_tick;
        (!flag_r && !tick_r) |=> !flag_r;
    endproperty
    a_ovr_only_on_tick: assert property (p_ovr_only_on_tick) else $error("set off tick");

    property p_tick_spacing;
        tick_r |=> !tick_r [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent");
endmodule

// [aes_thresh.sv]
// primary comparator flag with optional threshold counter
`timescale 1ns/1ps
module aes_thresh (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic                       comparator_en,
    input  wire logic                       counter_en,
    input  wire logic                       result_valid,
    input  wire logic [aes_pkg::RES_W-1:0]  result,
    input  wire logic [aes_pkg::RES_W-1:0]  level,
    input  wire logic [aes_pkg::CNT_W-1:0]  count_limit,
    output logic [aes_pkg::CNT_W-1:0]       count_value_r,
    output logic                            flag_r
);
    // sign-independent magnitude of a two's complement result
    function automatic logic [aes_pkg::RES_W-1:0] mag(input logic [aes_pkg::RES_W-1:0] v);
        mag = v[aes_pkg::RES_W-1] ? (~v + 1'b1) : v;
    endfunction

    logic                      exceed;
    logic [aes_pkg::CNT_W-1:0] count_nxt;

    assign exceed    = mag(result) > level;
    assign count_nxt = count_value_r + {{(aes_pkg::CNT_W-1){1'b0}}, 1'b1};

    // qualifying-result counter; saturates at the limit
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_value_r <= '0;
        end else if (!comparator_en || !counter_en) begin
            count_value_r <= '0;
        end else if (result_valid && exceed && count_value_r != count_limit) begin
            count_value_r <= count_nxt;
        end
    end

    // flag follows each result; with counter only once the count meets the limit
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_r <= 1'b0;
        end else if (!comparator_en) begin
            flag_r <= 1'b0;
        end else if (result_valid) begin
            if (counter_en) begin
                flag_r <= exceed
                          && (count_nxt == count_limit || count_value_r == count_limit);
            end else begin
                flag_r <= exceed;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_thex_direct;
        (comparator_en && !counter_en && result_valid) |=> (flag_r == $past(exceed));
    endproperty
    a_thex_direct: assert property (p_thex_direct) else $error("comparator flag wrong");

    property p_thex_count;
        (comparator_en && counter_en && result_valid && count_nxt != count_limit
         && count_value_r != count_limit) |=> !flag_r;
    endproperty
    a_thex_count: assert property (p_thex_count) else $error("flag before count limit");
endmodule

// [aes_dp_model.sv]
// behavioural conversion datapath that raises events toward the status block
`timescale 1ns/1ps
module aes_dp_model (
    input  wire logic         core_clk,
    output aes_pkg::aes_evt_t evt
);
    // all events quiet until the bench asks for one
    initial evt = '0;

    // one-cycle pulse: 0 primary, 1 aux, 2 calibration end, 3 gain change
    task automatic send(input int k, input logic [23:0] v);
        @(posedge core_clk);
        evt.prim_valid  <= (k == 0);
        evt.aux_valid   <= (k == 1);
        evt.cal_done    <= (k == 2);
        evt.gain_change <= (k == 3);
        evt.prim_result <= v;
        evt.aux_result  <= v;
        @(posedge core_clk);
        {evt.prim_valid, evt.aux_valid, evt.cal_done, evt.gain_change} <= 4'h0;
        // released result lines must not keep showing the stale word
        evt.prim_result <= ~v;
        evt.aux_result  <= ~v;
    endtask

    // detector, power state and accumulator are levels, held until changed
    task automatic level(input logic go, input logic pd, input logic [31:0] acc);
        @(posedge core_clk);
        evt.gross_over          <= go;
        evt.core_powered_down   <= pd;
        evt.primary_accumulator <= acc;
    endtask
endmodule

// [testbench.sv]
// self-checking bench for the converter event status block
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] EA = aes_pkg::IRQ_EN_ADDR;
    localparam logic [31:0] PA = aes_pkg::PRIM_DATA_ADDR;
    localparam logic [31:0] XA = aes_pkg::AUX_DATA_ADDR;
    logic              core_clk;
    logic              rst_b;
    aes_pkg::aes_cfg_t cfg;
    aes_pkg::aes_evt_t evt;
    logic [31:0]       mmr_addr;
    logic              mmr_rd;
    logic              mmr_wr;
    logic [31:0]       mmr_wdata;
    logic [31:0]       mmr_rdata_r;
    logic [15:0]       converter_event_status_r;
    logic              converter_irq_r;
    int                err_count;
    int                checks;
    int                n;
    logic [31:0]       d;
    logic [23:0]       v;
    logic [23:0]       x;
    logic [7:0]        en;
    logic [7:0]        es;
    logic [7:0]        tbl [8] = '{8'h40, 8'h10, 8'h08, 8'h02, 8'h01, 8'h00, 8'ha4, 8'hff};

    aes_top u_aes_top (.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .evt(evt),
        .mmr_addr(mmr_addr), .mmr_rd(mmr_rd), .mmr_wr(mmr_wr), .mmr_wdata(mmr_wdata),
        .mmr_rdata_r(mmr_rdata_r), .converter_event_status_r(converter_event_status_r),
        .converter_irq_r(converter_irq_r));
    aes_dp_model u_aes_dp_model (.core_clk(core_clk), .evt(evt));

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic results();
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask

    // whole status image against the tracked expectation
    task automatic cs(input string m);
        chk({16'h0, converter_event_status_r}, {24'h0, es}, m);
    endtask

    task automatic ci(input logic e);
        chk({31'h0, converter_irq_r}, {31'h0, e}, "interrupt level");
    endtask

    // request held until the sampling edge, dropped right after it
    task automatic wr(input logic [31:0] a, input logic [31:0] w);
        @(posedge core_clk);
        mmr_addr  <= a;
        mmr_wdata <= w;
        mmr_wr    <= 1'b1;
        @(posedge core_clk);
        mmr_wr <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        @(posedge core_clk);
        mmr_addr <= a;
        mmr_rd   <= 1'b1;
        @(posedge core_clk);
        mmr_rd <= 1'b0;
        #1;
        q = mmr_rdata_r;
    endtask

    // bounded wait for a status bit; the period is 3125 cycles, so 3300 is ample
    task automatic wt(input int b, output int c);
        c = 0;
        while (converter_event_status_r[b] !== 1'b1) begin
            cyc(1);
            c++;
            if (c > 3300) begin
                err_count++;
                $display("ERROR %0t wait for status bit %0d ran out", $time, b);
                results();
            end
        end
    endtask

    task automatic pr(input logic [23:0] r);
        u_aes_dp_model.send(0, r);
        cyc(1);
    endtask

    // sign-independent compare, strictly greater
    function automatic logic ex(input logic [23:0] r, input logic [23:0] l);
        logic [23:0] m;
        m = r[23] ? -r : r;
        return m > l;
    endfunction

    initial begin
        n = $urandom(32'ha0c3_916f);
        {err_count, checks, es} = '0;
        rst_b = 1'b0;
        cfg = '0;
        {mmr_addr, mmr_rd, mmr_wr, mmr_wdata} = '0;
        cfg.prim_en = 1'b1;
        cfg.aux_en = 1'b1;
        cfg.comparator_en = 1'b1;
        cfg.primary_threshold_level = 24'h7f_ffff;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(EA, d);
        chk(d, 32'h0000_0000, "enable after reset");
        cs("status after reset");
        for (int i = 0; i < 6; i++) begin
            en = (i == 0) ? 8'hff : 8'($urandom);
            wr(EA, {24'h0, en});
            rd(EA, d);
            chk(d, {24'h0, en & aes_pkg::IRQ_EN_MASK}, "enable readback");
        end
        wr(32'hffff_05f0, 32'hffff_ffff);
        rd(32'hffff_05f0, d);
        chk(d, 32'h0000_0000, "unmapped read");
        wr(aes_pkg::STATUS_ADDR, 32'hffff_ffff);
        wr(EA, 32'h0000_0001);
        // primary ready, drop while set, clear by read
        v = 24'($urandom) & 24'h3f_ffff;
        pr(v);
        es = 8'h01;
        cs("primary ready");
        ci(1'b1);
        pr(~v);
        rd(PA, d);
        chk({8'h0, d[23:0]}, {8'h0, v}, "result kept while ready");
        cyc(1);
        es = 8'h00;
        cs("primary read clears");
        ci(1'b0);
        // aux ready needs aux read then primary read
        wr(EA, 32'h0000_0002);
        u_aes_dp_model.send(1, v);
        cyc(1);
        es = 8'h02;
        cs("aux ready");
        ci(1'b1);
        rd(PA, d);
        cyc(1);
        cs("primary read alone keeps aux");
        rd(XA, d);
        chk({8'h0, d[23:0]}, {8'h0, v}, "aux data");
        rd(PA, d);
        cyc(1);
        es = 8'h00;
        cs("aux then primary read clears");
        u_aes_dp_model.send(2, 24'h0);
        cyc(1);
        es = 8'h03;
        cs("calibration end");
        rd(XA, d);
        rd(PA, d);
        cyc(1);
        es = 8'h00;
        cs("ready cleared after calibration");
        // comparator: boundary cases then random results
        cfg.primary_threshold_level = 24'($urandom_range(1, 32'h007f_fff0));
        wr(EA, 32'h0000_0010);
        for (int i = 0; i < 10; i++) begin
            x = cfg.primary_threshold_level;
            x = (i == 0) ? x : (i == 1) ? -x : (i == 2) ? x + 24'h1 : 24'($urandom);
            pr(x);
            es = {3'b0, ex(x, cfg.primary_threshold_level), 4'h1};
            cs("comparator flag");
            rd(PA, d);
            cyc(1);
            es[0] = 1'b0;
            ci(es[4]);
        end
        // threshold counter with a limit of three
        cfg.primary_threshold_level = 24'h00_0100;
        cfg.threshold_count_limit = 8'd3;
        cfg.counter_en = 1'b1;
        for (int i = 1; i <= 3; i++) begin
            pr(24'h00_0200);
            es = {3'b0, (i == 3), 4'h1};
            cs("counted comparator flag");
            rd(PA, d);
            cyc(1);
        end
        es[0] = 1'b0;
        cfg.counter_en = 1'b0;
        // overrange: periodic update, sticky until disable or gain change
        cfg.overrange_en = 1'b1;
        u_aes_dp_model.level(1'b1, 1'b0, 32'h0);
        wt(3, n);
        u_aes_dp_model.send(3, 24'h0);
        cyc(1);
        chk({31'h0, converter_event_status_r[3]}, 32'h0, "gain change clears");
        wt(3, n);
        chk({31'h0, (n > 3115 && n < 3126)}, 32'h1, "overrange period");
        es[3] = 1'b1;
        u_aes_dp_model.level(1'b0, 1'b0, 32'h0);
        cyc(3200);
        cs("overrange sticky");
        // accumulator threshold, equal then above
        cfg.accum_threshold_level = 32'h1234_5678;
        u_aes_dp_model.level(1'b0, 1'b0, 32'h1234_5678);
        cyc(2);
        cs("accumulator equal");
        u_aes_dp_model.level(1'b0, 1'b0, 32'h1234_5679);
        cyc(2);
        es[6] = 1'b1;
        cs("accumulator above");
        u_aes_dp_model.send(2, 24'h0);
        cyc(1);
        es = 8'h5b;
        cs("all flags set");
        rd(aes_pkg::STATUS_ADDR, d);
        chk(d, {24'h0, es}, "status read");
        // each source gated by its own enable bit
        for (int i = 0; i < 16; i++) begin
            en = (i < 8) ? tbl[i] : 8'($urandom);
            wr(EA, {24'h0, en});
            cyc(3);
            ci(|(en & es));
        end
        cfg.overrange_en = 1'b0;
        cyc(3);
        es[3] = 1'b0;
        cs("overrange disable clears");
        // powered-down core overwrites despite ready set
        u_aes_dp_model.level(1'b0, 1'b1, 32'h1234_5679);
        pr(24'h00_0042);
        rd(PA, d);
        chk({8'h0, d[23:0]}, 32'h0000_0042, "powered-down overwrite");
        results();
    end
endmodule
